// File: rtc_sched_pkg.sv
// constants, field layouts and types of the scheduled-event off-action block
// assumes a 50 MHz system clock and an apb master with 32-bit data
package rtc_sched_pkg;

    // timing
    localparam longint unsigned CLK_HZ         = 64'd50000000;
    localparam longint unsigned MINUTE_SECONDS = 64'd60;
    localparam logic [31:0]     MINUTE_CYCLES  = 32'(MINUTE_SECONDS * CLK_HZ);

    // event table
    localparam int          NUM_EVENTS = 20;
    localparam logic [4:0]  LAST_EVENT = 5'h13;
    localparam logic [4:0]  HOUR_MAX   = 5'h17;
    localparam logic [5:0]  MINUTE_MAX = 6'h3b;

    // action codes
    localparam logic [4:0]  ACT_NONE      = 5'h00;
    localparam logic [4:0]  ACT_SETUP1    = 5'h01;
    localparam logic [4:0]  ACT_PRESET1   = 5'h05;
    localparam logic [4:0]  ACT_AOUT1_OFF = 5'h09;
    localparam logic [4:0]  ACT_RELAY1_ON = 5'h0d;
    localparam logic [4:0]  ACT_START     = 5'h11;
    localparam logic [4:0]  ACT_STOP      = 5'h12;

    // action groups
    localparam logic [2:0]  GRP_NONE   = 3'h0;
    localparam logic [2:0]  GRP_SETUP  = 3'h1;
    localparam logic [2:0]  GRP_PRESET = 3'h2;
    localparam logic [2:0]  GRP_AOUT   = 3'h3;
    localparam logic [2:0]  GRP_RELAY  = 3'h4;
    localparam logic [2:0]  GRP_DRIVE  = 3'h5;

    // start-up policy
    localparam logic        POLICY_EXEC = 1'b0;
    localparam logic        POLICY_WAIT = 1'b1;

    // register byte offsets
    localparam logic [11:0] REG_CTRL    = 12'h000;
    localparam logic [11:0] REG_TIME    = 12'h004;
    localparam logic [11:0] REG_STATUS  = 12'h008;
    localparam logic [11:0] REG_SELECT  = 12'h00c;
    localparam logic [11:0] REG_EVT_ON  = 12'h010;
    localparam logic [11:0] REG_EVT_OFF = 12'h014;

    // field positions
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_POLICY_BIT  = 1;
    localparam int FLD_ACT_LSB      = 0;
    localparam int FLD_MIN_LSB      = 8;
    localparam int FLD_HOUR_LSB     = 16;
    localparam int STAT_REFUSED_BIT = 8;
    localparam int STAT_BUSY_BIT    = 9;

    // reset values
    localparam logic CTRL_ENABLE_RESET = 1'b0;
    localparam logic CTRL_POLICY_RESET = POLICY_WAIT;

    typedef enum {st_idle, st_scan, st_catch} scan_state_type;

    typedef struct packed {
        logic [4:0] hour;
        logic [5:0] minute;
    } tod_type;

    typedef struct packed {
        tod_type    on_time;
        logic [4:0] on_act;
        tod_type    off_time;
        logic [4:0] off_act;
    } event_type;

    typedef struct packed {
        logic       valid;
        logic [4:0] code;
    } action_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    function automatic logic [2:0] action_group(input logic [4:0] code);
        if (code >= ACT_START && code <= ACT_STOP)
            return GRP_DRIVE;
        else if (code >= ACT_RELAY1_ON)
            return (code < ACT_START) ? GRP_RELAY : GRP_NONE;
        else if (code >= ACT_AOUT1_OFF)
            return GRP_AOUT;
        else if (code >= ACT_PRESET1)
            return GRP_PRESET;
        else if (code >= ACT_SETUP1)
            return GRP_SETUP;
        return GRP_NONE;
    endfunction

    function automatic logic tod_ok(input tod_type t);
        return (t.hour <= HOUR_MAX) && (t.minute <= MINUTE_MAX);
    endfunction

endpackage

// File: rtc_event_off_scheduler.sv
// time-of-day event scheduler: twenty on/off events, apb register access
// assumes apb inputs are synchronous to i_sys_clk; i_reset is synchronous
// Overview of operation
// R01: off action codes 0 to 18
// R02: off actions reset to no action
// R03: off time reached runs that index's off action
// R04: unrelated off action is refused
// R05: policy 0 runs past on actions
// R06: start-up policy resets to wait
// R07: software must choose policy when enabling
// R08: actions grouped 1-4,5-8,9-12,13-16,17-18
// R09: twenty events, times 00.00 to 23.59
// R10: events may overlap independently
// R11: minute compare, each action once daily
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module rtc_event_off_scheduler
#(
    parameter logic [31:0] p_minute_cycles = rtc_sched_pkg::MINUTE_CYCLES
)
(
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_reset,
    input  wire rtc_sched_pkg::apb_req_type i_apb,
    output      rtc_sched_pkg::apb_rsp_type o_apb,
    output      rtc_sched_pkg::action_type  o_action
);
    import rtc_sched_pkg::*;

    // register group
    logic        enable;
    logic        policy;
    logic [4:0]  sel_idx;
    logic        refused;
    event_type   events [NUM_EVENTS];
    apb_rsp_type rsp;
    logic        next_enable;
    logic        next_policy;
    logic [4:0]  next_sel_idx;
    logic        next_refused;
    event_type   next_events [NUM_EVENTS];
    apb_rsp_type next_rsp;
    // time group
    logic [31:0] minute_cnt;
    tod_type     now;
    logic        tick;
    logic [31:0] next_minute_cnt;
    tod_type     next_now;
    logic        next_tick;
    // scan group
    scan_state_type state;
    logic [4:0]     ptr;
    logic           phase;
    logic           enable_d;
    tod_type        scan_time;
    action_type     action;
    logic [4:0]     last_code;
    scan_state_type next_state;
    logic [4:0]     next_ptr;
    logic           next_phase;
    tod_type        next_scan_time;
    action_type     next_action;
    logic [4:0]     next_last_code;
    // shared decode
    logic        setup;
    logic        wr_done;
    logic        time_wr;
    tod_type     wr_tod;
    logic [4:0]  wr_act;
    event_type   cur;
    logic        fire_on;
    logic        fire_off;
    logic        same_group;
    logic        refuse_evt;
    assign setup   = i_apb.psel && !i_apb.penable;
    assign wr_done = i_apb.psel && i_apb.penable && rsp.pready && i_apb.pwrite;
    assign wr_tod  = '{hour:   i_apb.pwdata[FLD_HOUR_LSB +: 5],
                       minute: i_apb.pwdata[FLD_MIN_LSB +: 6]};
    assign wr_act  = i_apb.pwdata[FLD_ACT_LSB +: 5];
    assign time_wr = wr_done && i_apb.paddr == REG_TIME && tod_ok(wr_tod);

    always_comb
    begin
        next_enable  = enable;
        next_policy  = policy;
        next_sel_idx = sel_idx;
        next_refused = refused;
        next_events  = events;
        next_rsp     = '{pready: setup, pslverr: 1'b0, prdata: rsp.prdata};
        if (setup)
        begin
            next_rsp.prdata = 32'h0;
            case (i_apb.paddr)
                REG_CTRL:
                begin
                    next_rsp.prdata[CTRL_ENABLE_BIT] = enable;
                    next_rsp.prdata[CTRL_POLICY_BIT] = policy;
                end
                REG_TIME:
                begin
                    next_rsp.prdata[FLD_HOUR_LSB +: 5] = now.hour;
                    next_rsp.prdata[FLD_MIN_LSB +: 6]  = now.minute;
                end
                REG_STATUS:
                begin
                    next_rsp.prdata[FLD_ACT_LSB +: 5]   = last_code;
                    next_rsp.prdata[STAT_REFUSED_BIT] = refused;
                    next_rsp.prdata[STAT_BUSY_BIT]    = state != st_idle;
                end
                REG_SELECT:
                    next_rsp.prdata[4:0] = sel_idx;
                REG_EVT_ON:
                begin
                    next_rsp.prdata[FLD_HOUR_LSB +: 5] = events[sel_idx].on_time.hour;
                    next_rsp.prdata[FLD_MIN_LSB +: 6]  = events[sel_idx].on_time.minute;
                    next_rsp.prdata[FLD_ACT_LSB +: 5]  = events[sel_idx].on_act;
                end
                REG_EVT_OFF:
                begin
                    next_rsp.prdata[FLD_HOUR_LSB +: 5] = events[sel_idx].off_time.hour;
                    next_rsp.prdata[FLD_MIN_LSB +: 6]  = events[sel_idx].off_time.minute;
                    next_rsp.prdata[FLD_ACT_LSB +: 5]  = events[sel_idx].off_act;
                end
                default:
                    next_rsp.pslverr = 1'b1;
            endcase
        end
        if (wr_done)
        begin
            case (i_apb.paddr)
                REG_CTRL:
                begin
                    next_enable = i_apb.pwdata[CTRL_ENABLE_BIT];
                    next_policy = i_apb.pwdata[CTRL_POLICY_BIT]; // R07
                end
                REG_STATUS:
                    if (i_apb.pwdata[STAT_REFUSED_BIT])
                        next_refused = 1'b0;
                REG_SELECT:
                    if (i_apb.pwdata[4:0] <= LAST_EVENT)
                        next_sel_idx = i_apb.pwdata[4:0]; // R09
                REG_EVT_ON:
                    if (tod_ok(wr_tod) && wr_act <= ACT_STOP) // R01 R09
                    begin
                        next_events[sel_idx].on_time = wr_tod;
                        next_events[sel_idx].on_act  = wr_act;
                    end
                REG_EVT_OFF:
                    if (tod_ok(wr_tod) && wr_act <= ACT_STOP) // R01 R09
                    begin
                        next_events[sel_idx].off_time = wr_tod;
                        next_events[sel_idx].off_act  = wr_act;
                    end
                default:
                    next_refused = refused;
            endcase
        end
        if (refuse_evt)
            next_refused = 1'b1;
        if (i_reset)
        begin
            next_enable  = CTRL_ENABLE_RESET;
            next_policy  = CTRL_POLICY_RESET; // R06
            next_sel_idx = 5'h00;
            next_refused = 1'b0;
            next_rsp     = '0;
            next_events  = '{default: '0}; // R02
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        enable  <= next_enable;
        policy  <= next_policy;
        sel_idx <= next_sel_idx;
        refused <= next_refused;
        events  <= next_events;
        rsp     <= next_rsp;
    end

    // minute time base and time of day
    always_comb
    begin
        next_minute_cnt = minute_cnt + 32'h1;
        next_now        = now;
        next_tick       = 1'b0;
        if (minute_cnt >= p_minute_cycles - 32'h1)
        begin
            next_minute_cnt = 32'h0;
            next_tick       = 1'b1; // R11
            if (now.minute == MINUTE_MAX)
            begin
                next_now.minute = 6'h00;
                next_now.hour   = (now.hour == HOUR_MAX) ? 5'h00 : now.hour + 5'h1; // R09
            end
            else
                next_now.minute = now.minute + 6'h1;
        end
        if (time_wr)
        begin
            next_now        = wr_tod;
            next_minute_cnt = 32'h0;
        end
        if (i_reset)
        begin
            next_minute_cnt = 32'h0;
            next_now        = '0;
            next_tick       = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        minute_cnt <= next_minute_cnt;
        now        <= next_now;
        tick       <= next_tick;
    end

    // event scan: each index checked on its own, so events may overlap
    assign cur        = events[ptr]; // R10
    assign same_group = action_group(cur.on_act) == action_group(cur.off_act)
                        && action_group(cur.off_act) != GRP_NONE; // R08
    assign fire_on    = !phase && cur.on_act != ACT_NONE
                        && ((state == st_scan && cur.on_time == scan_time) // R11
                        || (state == st_catch && cur.on_time <= scan_time)); // R05
    assign fire_off   = phase && state == st_scan && cur.off_act != ACT_NONE
                        && cur.off_time == scan_time; // R03
    assign refuse_evt = fire_off && !same_group; // R04

    always_comb
    begin
        next_state     = state;
        next_ptr       = ptr;
        next_phase     = phase;
        next_scan_time = scan_time;
        next_action    = '{valid: 1'b0, code: ACT_NONE};
        next_last_code = last_code;
        case (state)
            st_idle:
            begin
                next_ptr   = 5'h00;
                next_phase = 1'b0;
                if (enable && !enable_d && policy == POLICY_EXEC)
                begin
                    next_state     = st_catch; // R05
                    next_scan_time = now;
                end
                else if (enable && tick)
                begin
                    next_state     = st_scan; // R11
                    next_scan_time = now;
                end
            end
            st_scan, st_catch:
            begin
                if (fire_on)
                    next_action = '{valid: 1'b1, code: cur.on_act};
                else if (fire_off && same_group)
                    next_action = '{valid: 1'b1, code: cur.off_act}; // R03 R04
                if (next_action.valid)
                    next_last_code = next_action.code;
                if (state == st_scan && !phase)
                    next_phase = 1'b1;
                else
                begin
                    next_phase = 1'b0;
                    if (ptr == LAST_EVENT)
                        next_state = st_idle;
                    else
                        next_ptr = ptr + 5'h1;
                end
            end
            default:
                next_state = st_idle;
        endcase
        if (i_reset)
        begin
            next_state     = st_idle;
            next_ptr       = 5'h00;
            next_phase     = 1'b0;
            next_scan_time = '0;
            next_action    = '0;
            next_last_code = ACT_NONE;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        state     <= next_state;
        ptr       <= next_ptr;
        phase     <= next_phase;
        scan_time <= next_scan_time;
        action    <= next_action;
        last_code <= next_last_code;
        enable_d  <= i_reset ? 1'b0 : enable;
    end

    assign o_apb    = rsp;
    assign o_action = action;

    // checks
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence scan_begins;
        state == st_idle && enable && tick && !(!enable_d && policy == POLICY_EXEC);
    endsequence
    sequence scan_runs;
        state == st_scan [*8];
    endsequence
    a_action_code_range: assert property ( // R01
        o_action.valid |-> o_action.code != ACT_NONE && o_action.code <= ACT_STOP)
        else $error("action code outside 1..18");
    a_reset_off_none: assert property (disable iff (1'b0) // R02
        i_reset |=> events[0].off_act == ACT_NONE && events[LAST_EVENT].off_act == ACT_NONE)
        else $error("off action not cleared by reset");
    a_off_executes: assert property ( // R03
        fire_off && same_group && !fire_on |=> o_action.valid
        && o_action.code == $past(cur.off_act))
        else $error("matching off action not issued");
    a_off_refused: assert property ( // R04
        refuse_evt |=> !o_action.valid && refused)
        else $error("unrelated off action not refused");
    a_catch_policy: assert property ( // R05
        state == st_idle && enable && !enable_d && policy == POLICY_WAIT
        |=> state != st_catch)
        else $error("catch-up pass under wait policy");
    a_reset_policy: assert property (disable iff (1'b0) // R06
        i_reset |=> policy == POLICY_WAIT && !enable)
        else $error("start-up policy reset value wrong");
    a_time_range: assert property ( // R09
        now.hour <= HOUR_MAX && now.minute <= MINUTE_MAX)
        else $error("time of day out of range");
    a_scan_bounded: assert property ( // R11
        scan_begins |=> scan_runs ##33 state == st_idle)
        else $error("scan pass length wrong");
    a_group_pairs: assert property ( // R08
        o_action.valid && $past(phase) |-> action_group(o_action.code)
        == action_group($past(cur.on_act)))
        else $error("off action from another group");
endmodule

// File: apb_operator.sv
// apb master model standing in for the operator's configuration software
// assumes one clock; the bench calls its tasks through the instance
`timescale 1ns/100ps
module apb_operator
(
    input  wire logic                       i_sys_clk,
    input  wire rtc_sched_pkg::apb_rsp_type i_rsp,
    output      rtc_sched_pkg::apb_req_type o_req
);
    import rtc_sched_pkg::*;

    initial o_req = '0;

    // one full transfer, held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge i_sys_clk);
        o_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_sys_clk);
        o_req.penable <= 1'b1;
        do
            @(posedge i_sys_clk);
        while (i_rsp.pready !== 1'b1);
        q = i_rsp.prdata;
        e = i_rsp.pslverr;
        // released bus shows inverted address and data
        o_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
    endtask

    // enabling always names the start-up policy as well
    task automatic set_ctrl(input logic en, input logic pol, output logic [31:0] q,
                            output logic e);
        xfer(1'b1, REG_CTRL, {30'h0, pol, en}, q, e);
    endtask
endmodule

// File: testbench.sv
// self-checking bench for the scheduled-event block
// assumes the apb master model and the scheduler with a short minute
`timescale 1ns/100ps
module testbench;
    import rtc_sched_pkg::*;
    localparam logic [31:0] mc = 32'd96;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    apb_req_type req;
    apb_rsp_type rsp;
    action_type  act;
    int          errors = 0;
    int          compares = 0;
    logic [32:0] bq[$];
    logic [4:0]  aq[$];
    logic [31:0] q;
    logic        e;

    always #10 clk = ~clk;

    rtc_event_off_scheduler #(.p_minute_cycles(mc)) dut
    (
        .i_sys_clk (clk),
        .i_reset   (rst),
        .i_apb     (req),
        .o_apb     (rsp),
        .o_action  (act)
    );

    apb_operator op (.i_sys_clk(clk), .i_rsp(rsp), .o_req(req));

    task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp || $isunknown(got))
        begin
            errors++;
            $display("[ERR] %0t bus got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_act(input logic [4:0] got, input logic [4:0] exp);
        compares++;
        if (got !== exp || $isunknown(got))
        begin
            errors++;
            $display("[ERR] %0t action got %h exp %h", $time, got, exp);
        end
    endtask

    // monitor: each finished transfer or issued action takes the oldest note
    always @(posedge clk)
    begin
        if (req.psel && req.penable && rsp.pready === 1'b1)
            cmp_bus({rsp.pslverr, req.pwrite ? 32'h0 : rsp.prdata}, bq.size() ? bq.pop_front() : 'x);
        if (!rst && act.valid !== 1'b0)
            cmp_act(act.code, aq.size() ? aq.pop_front() : 5'bx);
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err = 1'b0);
        bq.push_back({err, 32'h0});
        op.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err = 1'b0);
        bq.push_back({err, x});
        op.xfer(1'b0, a, 32'h0, q, e);
    endtask

    task automatic ctrl(input logic en, input logic pol);
        bq.push_back(33'h0);
        op.set_ctrl(en, pol, q, e);
    endtask

    task automatic evt(input int i, input logic [31:0] on, input logic [31:0] off);
        wr(REG_SELECT, 32'(i));
        wr(REG_EVT_ON, on);
        wr(REG_EVT_OFF, off);
    endtask

    function automatic logic [31:0] f(input int h, input int m, input logic [4:0] c);
        return {11'h0, 5'(h), 2'h0, 6'(m), 3'h0, c};
    endfunction

    function automatic int grp(input logic [4:0] c);
        return c == 0 ? 0 : c > 16 ? 5 : (c - 1) / 4 + 1;
    endfunction

    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        errors++;
        conclude();
    end

    initial
    begin
        int         m;
        int         g;
        logic [4:0] on;
        logic       refused;
        logic [4:0] ons[20];
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        m = $urandom(32'h5e90);
        rd(REG_CTRL, 32'h2);
        wr(REG_SELECT, 32'h13);
        rd(REG_EVT_OFF, 32'h0);
        wr(REG_SELECT, 32'h14);
        rd(REG_SELECT, 32'h13);
        rd(12'h018, 32'h0, 1'b1);
        wr(12'h01c, 32'h5, 1'b1);
        $display("test reset values done");
        m = $urandom_range(57);
        refused = 1'b0;
        for (int k = 1; k < 19; k++)
        begin
            g = grp(5'(k));
            on = g == 5 ? 5'(17 + $urandom_range(1)) : 5'((g - 1) * 4 + 1 + $urandom_range(3));
            if ($urandom_range(3) == 0)
                on = k > 16 ? 5'h1 : 5'h11;
            ons[k] = on;
            evt(k, f(10, m + 1, on), f(10, m + 1, 5'(k)));
            aq.push_back(on);
            if (grp(on) == g)
                aq.push_back(5'(k));
            refused |= grp(on) != g;
        end
        ons[19] = 5'hd;
        evt(19, f(10, m + 1, 5'hd), f(10, m + 2, 5'he));
        aq.push_back(5'hd);
        wr(REG_TIME, f(10, m, 5'h0));
        ctrl(1'b1, POLICY_WAIT);
        repeat (140) @(posedge clk);
        rd(REG_STATUS, {23'h0, refused, 3'h0, 5'hd});
        wr(REG_STATUS, 32'h100);
        rd(REG_STATUS, 32'hd);
        aq.push_back(5'he);
        repeat (100) @(posedge clk);
        $display("test off actions and groups done");
        ctrl(1'b0, POLICY_EXEC);
        wr(REG_TIME, f(12, 0, 5'h0));
        evt(1, f(12, 30, 5'h1), f(12, 40, 5'h1));
        ctrl(1'b1, POLICY_WAIT);
        repeat (30) @(posedge clk);
        ctrl(1'b0, POLICY_WAIT);
        for (int k = 2; k < 20; k++)
            aq.push_back(ons[k]);
        ctrl(1'b1, POLICY_EXEC);
        rd(REG_STATUS, 32'h20e);
        repeat (40) @(posedge clk);
        $display("test start-up policy done");
        wr(REG_EVT_OFF, f(12, 40, 5'h13));
        rd(REG_EVT_OFF, f(12, 40, 5'h1));
        wr(REG_EVT_ON, f(24, 0, 5'h1));
        rd(REG_EVT_ON, f(12, 30, 5'h1));
        repeat (200) @(posedge clk);
        cmp_act(5'(aq.size()), 5'h0);
        $display("test refused writes done");
        conclude();
    end
endmodule
